/* File: include/tbt_pkg.sv */
package tbt_pkg;
    // register offsets
    localparam logic [7:0] CTRL_ADDR = 8'hB1;
    localparam logic [7:0] COUNT_ADDR = 8'hB2;
    localparam logic [7:0] PERIOD_ADDR = 8'hB3;
    localparam logic [7:0] STATUS_ADDR = 8'hB4;
    localparam logic [7:0] MASK_ADDR = 8'hB5;
    // control field positions
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_CLR_BIT = 6;
    localparam int CTRL_SEL_HI = 5;
    localparam int CTRL_SEL_LO = 3;
    localparam int STATUS_MATCH_BIT = 0;
    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] PERIOD_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    // clock select codes
    typedef enum logic [2:0] {
        SEL_SECOND = 3'h0,
        SEL_MINUTE = 3'h1,
        SEL_HOUR = 3'h2,
        SEL_EIGHTH = 3'h3,
        SEL_SYS_DIV12 = 3'h4,
        SEL_FAST_DIV16 = 3'h5,
        SEL_FAST_DIV128 = 3'h6,
        SEL_FAST_DIV1024 = 3'h7
    } tbt_sel_t;
    // power modes
    typedef enum logic [2:0] {
        MODE_FULL_SPEED_ALL = 3'h0,
        MODE_FULL_SPEED_PERIPHERALS = 3'h1,
        MODE_LOW_SPEED_ALL = 3'h2,
        MODE_LOW_SPEED_PERIPHERALS = 3'h3,
        MODE_ALL_HALTED = 3'h4
    } tbt_mode_t;
endpackage : tbt_pkg

/* File: design/tbt_timer.sv */
// Function
// [R1] 8-bit auto-reload timer with mux, counter, comparator
// [R2] eight counting clocks from three-bit select
// [R3] select codes map to the eight sources
// [R4] watch ticks stop when slow oscillator stops
// [R5] system clock/12 runs except all halted
// [R6] fast divided sources only in full-speed modes
// [R7] enabled counter increments on falling clock edges
// [R8] disabled: clock gated, counter holds
// [R9] disabled: no match ever
// [R10] counter counts modulo period, cleared by match
// [R11] every match sets interrupt flag
// [R12] flag cleared by acknowledge or software
// [R13] clear bit zeroes counter, reads zero
// [R14] counter keeps running after match
// [R15] counter readable, not writable
// [R16] selected clock synchronised, falling edge pulse
// [R17] reserved control bits read zero
//
// The implementer's own choice: the strobed register port.
module tbt_timer
    import tbt_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // counting sources
    input wire logic SECOND_TICK,
    input wire logic MINUTE_TICK,
    input wire logic HOUR_TICK,
    input wire logic EIGHTH_SECOND_TICK,
    input wire logic SYS_DIV12_CLK,
    input wire logic FAST_DIV16_CLK,
    input wire logic FAST_DIV128_CLK,
    input wire logic FAST_DIV1024_CLK,
    // power state
    input wire logic SLOW_OSC_RUN,
    input wire logic [2:0] POWER_MODE,
    // interrupt
    input wire logic INT_ACK,
    output logic IRQ
);

    ////////////////////////////////////////////////////////////////////////
    // source selection

    function automatic logic fast_mode(input logic [2:0] mode);
        fast_mode = (mode == MODE_FULL_SPEED_ALL) || (mode == MODE_FULL_SPEED_PERIPHERALS);
    endfunction : fast_mode

    function automatic logic source_pick(
        input logic [2:0] sel,
        input logic [2:0] mode,
        input logic slow_run,
        input logic [7:0] src
    );
        logic fast;
        fast = fast_mode(mode);
        case (sel)
            SEL_SECOND, SEL_MINUTE, SEL_HOUR, SEL_EIGHTH: begin
                source_pick = src[sel] & slow_run; // R4
            end
            SEL_SYS_DIV12: begin
                source_pick = src[sel] & (mode != MODE_ALL_HALTED); // R5
            end
            default: begin
                source_pick = src[sel] & fast; // R6
            end
        endcase
    endfunction : source_pick

    logic enable_r;
    logic enable_nxt;
    logic [2:0] sel_r;
    logic [2:0] sel_nxt;
    logic [7:0] sources;
    logic gated_clk;

    assign sources = {FAST_DIV1024_CLK, FAST_DIV128_CLK, FAST_DIV16_CLK, SYS_DIV12_CLK,
                      EIGHTH_SECOND_TICK, HOUR_TICK, MINUTE_TICK, SECOND_TICK}; // R2
    assign gated_clk = enable_r & source_pick(sel_r, POWER_MODE, SLOW_OSC_RUN, sources); // R3 R8

    ////////////////////////////////////////////////////////////////////////
    // synchroniser and falling edge detect

    logic sync1_r;
    logic sync1_nxt;
    logic sync2_r;
    logic sync2_nxt;
    logic sync3_r;
    logic sync3_nxt;
    logic count_pulse;

    // edge detect reads only the settled stages
    assign count_pulse = sync3_r & ~sync2_r & enable_r; // R16 R7

    always_comb begin
        sync1_nxt = gated_clk;
        sync2_nxt = sync1_r;
        sync3_nxt = sync2_r;
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            sync3_r <= sync3_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register writes

    // one-hot register hit: ctrl, count, period, status, mask
    function automatic logic [4:0] reg_hit(input logic [7:0] addr);
        reg_hit = 5'h00;
        if (addr == CTRL_ADDR) begin
            reg_hit = 5'h01;
        end else if (addr == COUNT_ADDR) begin
            reg_hit = 5'h02;
        end else if (addr == PERIOD_ADDR) begin
            reg_hit = 5'h04;
        end else if (addr == STATUS_ADDR) begin
            reg_hit = 5'h08;
        end else if (addr == MASK_ADDR) begin
            reg_hit = 5'h10;
        end
    endfunction : reg_hit

    logic [4:0] hit;
    logic wr_ctrl;
    logic wr_period;
    logic wr_status;
    logic wr_mask;
    logic rd_status;
    logic clear_req;
    logic [7:0] period_r;
    logic [7:0] period_nxt;
    logic mask_r;
    logic mask_nxt;

    always_comb begin
        hit = reg_hit(REG_ADDR);
        wr_ctrl = REG_WR & hit[0];
        wr_period = REG_WR & hit[2];
        wr_status = REG_WR & hit[3];
        wr_mask = REG_WR & hit[4];
    end

    assign rd_status = REG_RD & hit[3];
    assign clear_req = wr_ctrl & REG_WDATA[CTRL_CLR_BIT]; // R13

    always_comb begin
        enable_nxt = enable_r;
        sel_nxt = sel_r;
        period_nxt = period_r;
        mask_nxt = mask_r;
        if (wr_ctrl) begin
            enable_nxt = REG_WDATA[CTRL_EN_BIT];
            sel_nxt = REG_WDATA[CTRL_SEL_HI:CTRL_SEL_LO];
        end
        if (wr_period) begin
            period_nxt = REG_WDATA;
        end
        if (wr_mask) begin
            mask_nxt = REG_WDATA[STATUS_MATCH_BIT];
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            enable_r <= CTRL_RESET[CTRL_EN_BIT];
            sel_r <= CTRL_RESET[CTRL_SEL_HI:CTRL_SEL_LO];
            period_r <= PERIOD_RESET;
            mask_r <= MASK_RESET[STATUS_MATCH_BIT];
        end else begin
            enable_r <= enable_nxt;
            sel_r <= sel_nxt;
            period_r <= period_nxt;
            mask_r <= mask_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // counter and comparator

    logic [7:0] count_r;
    logic [7:0] count_nxt;
    logic [7:0] count_inc;
    logic match;

    assign count_inc = count_r + 8'h01;
    // period 0 behaves as modulo 256
    assign match = count_pulse && (count_inc == period_r); // R9 R10

    // a clear write wins over count and match
    always_comb begin
        count_nxt = count_r; // R8 R15
        if (clear_req) begin
            count_nxt = COUNT_RESET; // R13
        end else if (match) begin
            count_nxt = COUNT_RESET; // R10 R14
        end else if (count_pulse) begin
            count_nxt = count_inc; // R1 R7
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            count_r <= COUNT_RESET;
        end else begin
            count_r <= count_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt flag

    logic flag_r;
    logic flag_nxt;
    logic flag_clear;

    assign flag_clear = INT_ACK | rd_status | (wr_status & REG_WDATA[STATUS_MATCH_BIT]);

    // a match wins over a clear in the same cycle
    always_comb begin
        flag_nxt = flag_r;
        if (match) begin
            flag_nxt = 1'b1; // R11
        end else if (flag_clear) begin
            flag_nxt = 1'b0; // R12
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    // registered copy keeps the flag and mask timing
    logic irq_r;
    logic irq_nxt;

    always_comb begin
        irq_nxt = flag_nxt & mask_nxt;
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    assign IRQ = irq_r;

    ////////////////////////////////////////////////////////////////////////
    // read data

    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    // read data zero outside the reply cycle
    always_comb begin
        rdata_nxt = 8'h00;
        if (REG_RD) begin
            if (hit[0]) begin
                rdata_nxt[CTRL_EN_BIT] = enable_r; // R13 R17
                rdata_nxt[CTRL_SEL_HI:CTRL_SEL_LO] = sel_r;
            end else if (hit[1]) begin
                rdata_nxt = count_r; // R15
            end else if (hit[2]) begin
                rdata_nxt = period_r;
            end else if (hit[3]) begin
                rdata_nxt[STATUS_MATCH_BIT] = flag_r;
            end else if (hit[4]) begin
                rdata_nxt[STATUS_MATCH_BIT] = mask_r;
            end
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign REG_RDATA = rdata_r;

endmodule : tbt_timer

/* File: sim/tbt_timer_checker.sv */
module tbt_timer_checker
    import tbt_pkg::*;
(
    // bus and interrupt
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic INT_ACK,
    input wire logic IRQ
);
    logic en_r;
    logic msk_r;
    logic [7:0] prd_r;
    // shadow of written settings
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            en_r <= 1'b0;
            msk_r <= 1'b0;
            prd_r <= 8'h00;
        end else if (REG_WR) begin
            if (REG_ADDR == CTRL_ADDR) en_r <= REG_WDATA[CTRL_EN_BIT];
            if (REG_ADDR == MASK_ADDR) msk_r <= REG_WDATA[0];
            if (REG_ADDR == PERIOD_ADDR) prd_r <= REG_WDATA;
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    rd_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00) else $error("read data not idle");
    ctrl_rsv_a: assert property ($past(REG_RD) && $past(REG_ADDR) == CTRL_ADDR
        |-> REG_RDATA[2:0] == 3'h0 && !REG_RDATA[CTRL_CLR_BIT]) else $error("control reads bad bits");
    unmap_zero_a: assert property ($past(REG_RD) && ($past(REG_ADDR) < CTRL_ADDR || $past(REG_ADDR) > MASK_ADDR)
        |-> REG_RDATA == 8'h00) else $error("unmapped read not zero");
    cnt_range_a: assert property ($past(REG_RD) && $past(REG_ADDR) == COUNT_ADDR && prd_r != 8'h00
        |-> REG_RDATA < prd_r) else $error("count beyond period");
    irq_mask_a: assert property (!msk_r |-> !IRQ) else $error("masked irq");
    off_quiet_a: assert property ($rose(IRQ) && $past(msk_r) |-> en_r) else $error("match while off");
    ack_clr_a: assert property (INT_ACK && !en_r |-> ##2 !IRQ) else $error("ack kept irq");
    rd_clr_a: assert property (REG_RD && REG_ADDR == STATUS_ADDR && !en_r |-> ##2 !IRQ)
        else $error("status read kept irq");
endmodule : tbt_timer_checker

bind tbt_timer tbt_timer_checker tbt_timer_checker_i (.REF_CLK(REF_CLK), .RST(RST), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .INT_ACK(INT_ACK), .IRQ(IRQ));

/* File: sim/tb_tbt_timer.sv */
module tb_tbt_timer
    import tbt_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [7:0] src = 8'h00;
    logic slow_run = 1'b1;
    logic [2:0] mode = MODE_FULL_SPEED_ALL;
    logic ack = 1'b0;
    logic irq;
    int error_cnt = 0;
    int checks = 0;
    tbt_timer tbt_timer_i (.REF_CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
        .REG_RD(rd), .REG_RDATA(rdata), .SECOND_TICK(src[0]), .MINUTE_TICK(src[1]), .HOUR_TICK(src[2]),
        .EIGHTH_SECOND_TICK(src[3]), .SYS_DIV12_CLK(src[4]), .FAST_DIV16_CLK(src[5]), .FAST_DIV128_CLK(src[6]),
        .FAST_DIV1024_CLK(src[7]), .SLOW_OSC_RUN(slow_run), .POWER_MODE(mode), .INT_ACK(ack), .IRQ(irq));
    initial forever #12.5 clk = ~clk;
    ////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rreg
    // falling edges on one counting source
    task automatic fall(input int i, input int n);
        repeat (n) begin
            src[i] <= 1'b1;
            repeat (4) @(posedge clk);
            src[i] <= 1'b0;
            repeat (6) @(posedge clk);
        end
    endtask : fall
    task automatic complete_run;
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    ////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int a = 8'hB0; a < 8'hB6; a++) rreg(a[7:0], 8'h00);
        wreg(MASK_ADDR, 8'h01);
        wreg(COUNT_ADDR, 8'h55);
        rreg(COUNT_ADDR, 8'h00);
        wreg(CTRL_ADDR, 8'hFF);
        rreg(CTRL_ADDR, 8'hB8);
        wreg(PERIOD_ADDR, 8'h03);
        for (int s = 0; s < 8; s++) begin
            wreg(CTRL_ADDR, {2'b11, s[2:0], 3'h0});
            fall(s, 2);
            rreg(COUNT_ADDR, 8'h02);
        end
        fall(7, 1);
        rreg(COUNT_ADDR, 8'h00);
        chk({7'h00, irq}, 8'h01);
        fall(7, 1);
        rreg(COUNT_ADDR, 8'h01);
        wreg(CTRL_ADDR, 8'h38);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        repeat (2) @(posedge clk);
        chk({7'h00, irq}, 8'h00);
        fall(7, 2);
        rreg(COUNT_ADDR, 8'h01);
        chk({7'h00, irq}, 8'h00);
        wreg(CTRL_ADDR, 8'hB8);
        fall(7, 2);
        wreg(CTRL_ADDR, 8'h38);
        rreg(STATUS_ADDR, 8'h01);
        repeat (2) @(posedge clk);
        chk({7'h00, irq}, 8'h00);
        slow_run <= 1'b0;
        wreg(CTRL_ADDR, 8'hC0);
        fall(0, 1);
        rreg(COUNT_ADDR, 8'h00);
        mode <= MODE_ALL_HALTED;
        wreg(CTRL_ADDR, 8'hE0);
        fall(4, 1);
        rreg(COUNT_ADDR, 8'h00);
        mode <= MODE_LOW_SPEED_ALL;
        fall(4, 1);
        rreg(COUNT_ADDR, 8'h01);
        wreg(CTRL_ADDR, 8'hE8);
        fall(5, 1);
        rreg(COUNT_ADDR, 8'h00);
        mode <= MODE_FULL_SPEED_PERIPHERALS;
        fall(5, 1);
        rreg(COUNT_ADDR, 8'h01);
        mode <= MODE_LOW_SPEED_PERIPHERALS;
        wreg(CTRL_ADDR, 8'hE0);
        fall(4, 1);
        rreg(COUNT_ADDR, 8'h01);
        fall(4, 2);
        chk({7'h00, irq}, 8'h01);
        wreg(STATUS_ADDR, 8'h01);
        repeat (2) @(posedge clk);
        chk({7'h00, irq}, 8'h00);
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        complete_run();
    end
endmodule : tb_tbt_timer
